// file: logic/pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous inputs and one clock domain.
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] pin_in,
  output logic [W-1:0]      level_out
);
  initial
  begin
    if (W < 1) $error("pin_sync width must be positive");
  end

  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] lvl;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d    = s_q;
    s_d.f1 = pin_in;
    s_d.f2 = s_q.f1;
    s_d.f3 = s_q.f2;
    // Level follows once stages two and three agree
    s_d.lvl = (s_q.f3 & ~(s_q.f2 ^ s_q.f3)) | (s_q.lvl & (s_q.f2 ^ s_q.f3));
  end

  // Idle bus level after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '1;
    else
      s_q <= s_d;
  end

  assign level_out = s_q.lvl;
endmodule

// file: logic/pmon_port.sv
// Serial command port of the power monitor: slave, config, result.
// Assumes SCL and SDA as open-drain pins and a measurement engine
// that reports one signed count per finished operation.
//
// Summary of operation
// (R1) Result is signed, nine integer bits, six zeros
// (R2) Full scale 4000h, negative C000h, zero voltage
// (R3) One result register holds selected quantity
// (R4) All three read commands return that register
// (R5) Host avoids reserved codes; device refuses them
// (R6) Config write: command, low byte, high byte
// (R7) Config read: repeated start, low then high
// (R8) Read voltage code 8Bh, low byte first
// (R9) Read current code 8Ch, low byte first
// (R10) Read power code 96h, low byte first
// (R11) Acknowledge low, not-acknowledge left high
// (R12) Config bits 7:6 select quantity, power default
// (R13) New selection applies after pending operation ends
// (R14) Result latched at start of each read
`timescale 1ns/1ns
`include "pmon_consts.svh"
module pmon_port #(
  parameter logic [6:0] SLAVE_ADDR = 7'h40,
  parameter int         CW         = 10
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Serial bus pins
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  // Measurement engine
  input  wire logic                 meas_done,
  input  wire logic signed [CW-1:0] meas_count,
  output logic [15:0]               cfg_q,
  output pmon_pkg::quantity_t       quantity_sel_q
);
  import pmon_pkg::*;

  initial
  begin
    if (CW < 10 || CW > 16) $error("count width out of range");
  end

  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = (c == `CMD_CONFIG) || (c == `CMD_READ_VOLT) ||
                (c == `CMD_READ_CURR) || (c == `CMD_READ_PWR);
  endfunction

  typedef struct packed {
    port_state_t st;
    byte_kind_t  kind;
    logic [7:0]  sh;
    logic [3:0]  bitcnt;
    logic        rw;
    logic [7:0]  cmd;
    logic [7:0]  lo;
    logic [15:0] cfg;
    logic [15:0] hold;
    logic        tx_hi;
    logic        oe;
    logic        sda_o;
    quantity_t   sel;
    logic        scl_p;
    logic        sda_p;
  } port_state_s_t;

  port_state_s_t s_q;
  port_state_s_t s_d;
  logic [1:0]    lvl;
  logic [15:0]   result_q;
  logic          scl;
  logic          sda;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_c;
  logic          stop_c;

  ////////////////////////////////////////////////////////////////////
  pin_sync #(
    .W (2)
  ) u_sync (
    .clk       (clk),
    .rst       (rst),
    .pin_in    ({scl_in, sda_in}),
    .level_out (lvl)
  );

  result_format #(
    .CW (CW)
  ) u_fmt (
    .clk        (clk),
    .rst        (rst),
    .meas_done  (meas_done),
    .meas_count (meas_count),
    .meas_sel   (s_q.sel),
    .result_q   (result_q)
  );

  assign scl      = lvl[1];
  assign sda      = lvl[0];
  assign scl_rise = scl && !s_q.scl_p;
  assign scl_fall = !scl && s_q.scl_p;
  assign start_c  = scl && s_q.scl_p && s_q.sda_p && !sda;
  assign stop_c   = scl && s_q.scl_p && !s_q.sda_p && sda;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d       = s_q;
    s_d.scl_p = scl;
    s_d.sda_p = sda;
    if (meas_done)
      s_d.sel = s_q.cfg[`CFG_SEL_HI:`CFG_SEL_LO];            // R12 R13
    if (start_c)
    begin
      s_d.st     = ST_RX;
      s_d.kind   = K_ADDR;
      s_d.bitcnt = '0;
      s_d.oe     = 1'b0;
    end
    else if (stop_c)
    begin
      s_d.st = ST_IDLE;
      s_d.oe = 1'b0;
    end
    else
    begin
      case (s_q.st)
        ST_RX:
        begin
          if (scl_rise && s_q.bitcnt < 4'h8)
          begin
            s_d.sh     = {s_q.sh[6:0], sda};
            s_d.bitcnt = s_q.bitcnt + 4'h1;
          end
          else if (scl_fall && s_q.bitcnt == 4'h8)
          begin
            s_d.st = ST_RX_ACK;
            s_d.oe = 1'b1;                                   // R11
            case (s_q.kind)
              K_ADDR:
              begin
                s_d.rw   = s_q.sh[0];
                s_d.kind = K_CMD;
                if (s_q.sh[0])                               // R14 R4
                  s_d.hold = (s_q.cmd == `CMD_CONFIG) ? s_q.cfg : result_q;
                if (s_q.sh[7:1] != SLAVE_ADDR || (s_q.sh[0] && !known_cmd(s_q.cmd)))
                begin
                  s_d.st = ST_IDLE;
                  s_d.oe = 1'b0;                             // R11
                end
              end
              K_CMD:
              begin
                s_d.cmd  = s_q.sh;                           // R8 R9 R10
                s_d.kind = K_LO;
                if (!known_cmd(s_q.sh))
                begin
                  s_d.cmd = '0;
                  s_d.st  = ST_IDLE;                         // R5
                  s_d.oe  = 1'b0;
                end
              end
              K_LO:
              begin
                s_d.lo   = s_q.sh;                           // R6
                s_d.kind = K_HI;
                if (s_q.cmd != `CMD_CONFIG)
                begin
                  s_d.st = ST_IDLE;
                  s_d.oe = 1'b0;
                end
              end
              default:
              begin
                s_d.cfg  = {s_q.sh, s_q.lo};                 // R6 R12
                s_d.kind = K_ADDR;
                s_d.cmd  = '0;
              end
            endcase
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            s_d.bitcnt = '0;
            if (s_q.rw)
            begin
              s_d.st     = ST_TX;
              s_d.sh     = s_q.hold[7:0];                    // R7
              s_d.oe     = !s_q.hold[7];
              s_d.bitcnt = 4'h1;
              s_d.tx_hi  = 1'b0;
            end
            else
            begin
              s_d.oe = 1'b0;
              s_d.st = (s_q.kind == K_ADDR) ? ST_IDLE : ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (s_q.bitcnt == 4'h8)
            begin
              s_d.oe = 1'b0;
              s_d.st = ST_TX_ACK;
            end
            else
            begin
              s_d.sh     = {s_q.sh[6:0], 1'b0};
              s_d.oe     = !s_q.sh[6];
              s_d.bitcnt = s_q.bitcnt + 4'h1;
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)                                      // R11
            s_d.st = (!sda && !s_q.tx_hi) ? ST_TX_LOAD : ST_IDLE;
        end
        ST_TX_LOAD:
        begin
          if (scl_fall)
          begin
            s_d.st     = ST_TX;
            s_d.sh     = s_q.hold[15:8];                     // R7 R8 R9 R10
            s_d.oe     = !s_q.hold[15];
            s_d.bitcnt = 4'h1;
            s_d.tx_hi  = 1'b1;
          end
        end
        default:
        begin
          s_d.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.kind  <= K_ADDR;
      s_q.cfg   <= `CFG_RESET;
      s_q.sel   <= `SEL_POWER;                               // R12
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign sda_out        = s_q.sda_o;
  assign sda_oe         = s_q.oe;
  assign cfg_q          = s_q.cfg;
  assign quantity_sel_q = s_q.sel;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_idle_release;
    s_q.st == ST_IDLE |-> !sda_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("pin driven while idle"); // R11

  property p_ack_drive;
    s_q.st == ST_RX_ACK |-> sda_oe && !sda_out;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven low"); // R11

  property p_cfg_commit;
    $changed(cfg_q) |-> $past(s_q.st) == ST_RX && $past(s_q.kind) == K_HI
                        && $past(s_q.cmd) == `CMD_CONFIG;
  endproperty
  a_cfg_commit: assert property (p_cfg_commit) else $error("config changed off frame"); // R6

  property p_hold_src;
    $changed(s_q.hold) |-> s_q.hold == (($past(s_q.cmd) == `CMD_CONFIG)
                                        ? $past(s_q.cfg) : $past(result_q));
  endproperty
  a_hold_src: assert property (p_hold_src) else $error("read latch from wrong source"); // R4

  property p_hold_only_addr;
    $changed(s_q.hold) |-> $past(s_q.kind) == K_ADDR && $past(s_q.st) == ST_RX;
  endproperty
  a_hold_only_addr: assert property (p_hold_only_addr) else $error("latch moved mid read"); // R14

  property p_first_low;
    s_q.st == ST_RX_ACK && s_q.rw && scl_fall |=> s_q.sh == s_q.hold[7:0] && !s_q.tx_hi;
  endproperty
  a_first_low: assert property (p_first_low) else $error("low byte not first"); // R7

  property p_second_high;
    $rose(s_q.tx_hi) |-> s_q.sh == s_q.hold[15:8] && $past(s_q.st) == ST_TX_LOAD;
  endproperty
  a_second_high: assert property (p_second_high) else $error("high byte not second"); // R8

  property p_sel_update;
    meas_done |=> quantity_sel_q == $past(cfg_q[`CFG_SEL_HI:`CFG_SEL_LO]);
  endproperty
  a_sel_update: assert property (p_sel_update) else $error("selection not taken"); // R12

  property p_sel_wait;
    $changed(quantity_sel_q) |-> $past(meas_done);
  endproperty
  a_sel_wait: assert property (p_sel_wait) else $error("selection changed early"); // R13

  c_cfg_write: cover property ($changed(cfg_q));
  c_read_hi:   cover property ($rose(s_q.tx_hi));
  c_sel_volt:  cover property (quantity_sel_q == `SEL_VOLTAGE && meas_done);
endmodule

// file: logic/result_format.sv
// Measurement result register: saturate and pad the count.
// Assumes one signed count per finished measurement.
`timescale 1ns/1ns
`include "pmon_consts.svh"
module result_format #(
  parameter int CW = 10
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Finished measurement
  input  wire logic                 meas_done,
  input  wire logic signed [CW-1:0] meas_count,
  input  wire pmon_pkg::quantity_t  meas_sel,
  // Result word
  output logic [15:0]               result_q
);
  import pmon_pkg::*;

  initial
  begin
    if (CW != 16 - `RES_PAD_BITS) $error("count width must fill the result word");
  end

  typedef struct packed {
    logic [15:0] res;
  } fmt_state_t;

  fmt_state_t s_q;
  fmt_state_t s_d;
  logic signed [CW-1:0] sat;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    sat = meas_count;
    if (meas_count > `COUNT_POS_FS)
      sat = `COUNT_POS_FS;                                   // R2
    else if (meas_count < `COUNT_NEG_FS)
      sat = `COUNT_NEG_FS;                                   // R2
    if (meas_sel == `SEL_VOLTAGE && meas_count < 0)
      sat = '0;                                              // R2
    if (meas_done)
      s_d.res = {sat, {`RES_PAD_BITS{1'b0}}};                // R1 R3
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign result_q = s_q.res;

  ////////////////////////////////////////////////////////////////////
  property p_pad_zero;
    @(posedge clk) disable iff (rst) result_q[`RES_PAD_BITS-1:0] == '0;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("result pad bits not zero"); // R1

  property p_full_scale;
    @(posedge clk) disable iff (rst)
      meas_done && meas_count > `COUNT_POS_FS |=> result_q == `RES_POS_FS;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("positive full scale wrong"); // R2

  property p_neg_scale;
    @(posedge clk) disable iff (rst)
      meas_done && meas_sel != `SEL_VOLTAGE && meas_count < `COUNT_NEG_FS
      |=> result_q == `RES_NEG_FS;
  endproperty
  a_neg_scale: assert property (p_neg_scale) else $error("negative full scale wrong"); // R2

  property p_hold_result;
    @(posedge clk) disable iff (rst) !meas_done |=> $stable(result_q);
  endproperty
  a_hold_result: assert property (p_hold_result) else $error("result changed unasked"); // R3
endmodule

// file: shared/pmon_consts.svh
// Constants of the power monitor serial command port.
// Assumes inclusion by the package and the design modules.
`ifndef PMON_CONSTS_SVH
`define PMON_CONSTS_SVH

// Command codes
`define CMD_CONFIG       8'hD0
`define CMD_READ_VOLT    8'h8B
`define CMD_READ_CURR    8'h8C
`define CMD_READ_PWR     8'h96

// Configuration layout and reset value
`define CFG_RESET        16'h0000
`define CFG_SEL_HI       7
`define CFG_SEL_LO       6

// Quantity select codes
`define SEL_POWER        2'h0
`define SEL_VOLTAGE      2'h1
`define SEL_CURRENT      2'h2

// Result word format
`define RES_PAD_BITS     6
`define RES_POS_FS       16'h4000
`define RES_NEG_FS       16'hC000
`define COUNT_POS_FS     10'sh100
`define COUNT_NEG_FS     -10'sh100

`endif

// file: shared/pmon_pkg.sv
// Types of the power monitor serial command port.
// Assumes the constants header on the include path.
package pmon_pkg;
  `include "pmon_consts.svh"

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_TX_LOAD
  } port_state_t;

  typedef enum logic [1:0] {
    K_ADDR,
    K_CMD,
    K_LO,
    K_HI
  } byte_kind_t;

  typedef logic [1:0] quantity_t;
endpackage

// file: tb/power_monitor_smbus_port_bench.sv
// Bench of the power monitor serial port: config, results, refusals.
// Assumes the package, design and host model compiled before it.
`timescale 1ns/1ns
`include "pmon_consts.svh"
module power_monitor_smbus_port_bench;
  import pmon_pkg::*;
  localparam logic [6:0] DEV   = 7'h40;
  localparam int         LIMIT = 40000;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              meas_done = 1'b0;
  logic signed [9:0] meas_count = '0;
  logic              scl, sda_pull, sda_line, sda_out, sda_oe;
  logic [15:0]       cfg_q;
  quantity_t         quantity_sel_q;
  int                n_mismatch = 0;
  int                n_tests = 0;
  int                cycles = 0;

  always #10 clk = ~clk;
  assign sda_line = !((sda_oe && !sda_out) || sda_pull);

  pmon_port #(.SLAVE_ADDR(DEV), .CW(10)) u_pmon_port (.clk(clk), .rst(rst),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .meas_done(meas_done), .meas_count(meas_count), .cfg_q(cfg_q),
    .quantity_sel_q(quantity_sel_q));
  smbus_host u_smbus_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_word(input int c, input logic [1:0] s);
    int v;
    v = (s == `SEL_VOLTAGE && c < 0) ? 0 : c;
    v = (v > 256) ? 256 : (v < -256) ? -256 : v;
    return 16'(v * 64);
  endfunction

  task automatic pulse(input int c);
    @(negedge clk);
    meas_count = 10'(c);
    meas_done  = 1'b1;
    @(negedge clk);
    meas_done  = 1'b0;
    @(negedge clk);
  endtask

  task automatic set_sel(input logic [1:0] s);
    logic ok;
    u_smbus_host.write_word(DEV, `CMD_CONFIG, {8'h00, s, 6'h00}, ok);
    chk({15'h0, ok}, 16'h1, "config ack");
    pulse(0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] w;
    logic        ok;
    chk(cfg_q, `CFG_RESET, "cfg reset");
    chk({14'h0, quantity_sel_q}, 16'h0, "sel reset");
    u_smbus_host.read_word(DEV, `CMD_READ_PWR, w, ok);
    chk(w, 16'h0000, "reset result");
    $display("done t_reset");
  endtask

  task automatic t_config();
    logic [15:0] w;
    logic        ok;
    u_smbus_host.write_word(DEV, `CMD_CONFIG, 16'hA541, ok);
    chk({15'h0, ok}, 16'h1, "write acks");
    chk(cfg_q, 16'hA541, "cfg value");
    chk({14'h0, quantity_sel_q}, 16'h0, "sel before op");
    u_smbus_host.read_word(DEV, `CMD_CONFIG, w, ok);
    chk(w, 16'hA541, "cfg readback");
    pulse(0);
    chk({14'h0, quantity_sel_q}, 16'h1, "sel after op");
    $display("done t_config");
  endtask

  task automatic t_results();
    logic [7:0]  cmds [3] = '{`CMD_READ_VOLT, `CMD_READ_CURR, `CMD_READ_PWR};
    int          cnts [7] = '{300, 256, 5, 0, -1, -256, -300};
    logic [15:0] w;
    logic        ok;
    for (int s = 0; s < 3; s++)
    begin
      set_sel(2'(s));
      for (int i = 0; i < 7; i++)
      begin
        pulse(cnts[i]);
        u_smbus_host.read_word(DEV, cmds[(s + i) % 3], w, ok);
        chk({15'h0, ok}, 16'h1, "read acks");
        chk(w, exp_word(cnts[i], 2'(s)), "result");
      end
    end
    $display("done t_results");
  endtask

  task automatic t_latch();
    logic [15:0] w;
    logic        ok;
    set_sel(`SEL_POWER);
    pulse(5);
    fork
      u_smbus_host.read_word(DEV, `CMD_READ_PWR, w, ok);
      begin
        repeat (560) @(negedge clk);
        pulse(-256);
      end
    join
    chk(w, 16'h0140, "held word");
    u_smbus_host.read_word(DEV, `CMD_READ_CURR, w, ok);
    chk(w, `RES_NEG_FS, "next word");
    $display("done t_latch");
  endtask

  task automatic t_refuse();
    logic [7:0] codes [6] = '{8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD7, 8'hD8};
    logic       a0, a1;
    for (int i = 0; i < 6; i++)
    begin
      u_smbus_host.start_cond();
      u_smbus_host.send_byte({DEV, 1'b0}, a0);
      u_smbus_host.send_byte(codes[i], a1);
      u_smbus_host.stop_cond();
      chk({14'h0, a0, a1}, 16'h2, "reserved code");
    end
    u_smbus_host.start_cond();
    u_smbus_host.send_byte({DEV ^ 7'h01, 1'b0}, a0);
    u_smbus_host.stop_cond();
    chk({15'h0, a0}, 16'h0, "other address");
    chk(cfg_q, 16'h0000, "cfg kept");
    $display("done t_refuse");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_reset();
    t_config();
    t_results();
    t_latch();
    t_refuse();
    end_sim();
  end
endmodule

// file: tb/smbus_host.sv
// Host model of the serial bus: frames, bits and acknowledges.
// Assumes pull-ups on both lines and a bench clock for pacing.
`timescale 1ns/1ns
module smbus_host (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One bit; SDA moves mid low phase
  task automatic bit_io(input logic b, output logic r);
    tick(4);
    sda_pull = !b;
    tick(4);
    scl = 1'b1;
    tick(8);
    r = sda_line;
    scl = 1'b0;
  endtask

  // Start or repeated start
  task automatic start_cond();
    tick(4);
    sda_pull = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_pull = 1'b1;
    tick(8);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_pull = 1'b0;
    tick(8);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask

  task automatic write_word(input logic [6:0] a, input logic [7:0] cmd,
                            input logic [15:0] d, output logic ok);
    logic [3:0] k;
    start_cond();
    send_byte({a, 1'b0}, k[0]);
    send_byte(cmd, k[1]);
    send_byte(d[7:0], k[2]);
    send_byte(d[15:8], k[3]);
    stop_cond();
    ok = &k;
  endtask

  task automatic read_word(input logic [6:0] a, input logic [7:0] cmd,
                           output logic [15:0] d, output logic ok);
    logic [2:0] k;
    start_cond();
    send_byte({a, 1'b0}, k[0]);
    send_byte(cmd, k[1]);
    start_cond();
    send_byte({a, 1'b1}, k[2]);
    recv_byte(1'b0, d[7:0]);
    recv_byte(1'b1, d[15:8]);
    stop_cond();
    ok = &k;
  endtask
endmodule
